// ---- rtl/sfre_device.sv ----
// Overview of operation
// RQ1: Fast read: opcode, address, dummy, then data
// RQ2: Slow read: data right after address
// RQ3: Host sends exactly three address bytes
// RQ4: Address counter advances as data leaves
// RQ5: Single lane shifts MSB first
// RQ6: Counter wraps top to zero, no gap
// RQ7: Chip select release ends read, tri-states
// RQ8: Dual output: one-lane address, dummy, two-lane data
// RQ9: Two lanes: high bit on SO, four clocks
// RQ10: Release tri-states both SO and SI
// RQ11: Dual IO: two-lane address, mode, data
// RQ12: Mode bits 10 skip next opcode
// RQ13: Other mode bits restore opcode decoding
// RQ14: Lower mode nibble is ignored
// RQ15: Host releases lanes before first data fall
// RQ16: Mode reset command clears continuous mode
// RQ17: Quad read only with permit bit set
// RQ18: Quad output: one-lane header, four-lane data
// RQ19: Four lanes: high nibble first, two clocks
// RQ20: Release tri-states all four lanes
// RQ21: Unknown opcode ignored until chip select cycles
// RQ22: Top four address bits ignored
// RQ23: Sixteen ones leave continuous mode
// RQ24: Mode byte over four clocks, data next
//
`timescale 1ns/1ps
module sfre_device
    import sfre_pkg::*;
(
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    // Serial link
    sfre_link_if.dev                        link,
    // Configuration
    input  wire logic                       quad_lane_permit_bit,
    // Array load port
    input  wire logic                       load_en,
    input  wire logic [ARRAY_ADDR_BITS-1:0] load_addr,
    input  wire logic [7:0]                 load_data,
    // Status
    output logic                            read_active,
    output logic                            cont_read_active
);

    typedef enum logic [2:0] {
        D_IDLE,
        D_OPC,
        D_ADDR,
        D_MODE,
        D_DUMMY,
        D_DATA,
        D_IGNORE
    } sfre_dev_state_t;

    sfre_dev_state_t state;
    logic [7:0]      mem [0:ARRAY_BYTES-1];
    logic            cs_s1;
    logic            cs_s2;
    logic            sck_s1;
    logic            sck_s2;
    logic            sck_d;
    logic [3:0]      io_s1;
    logic [3:0]      io_s2;
    logic            sck_rise;
    logic            sck_fall;
    logic [7:0]      opc;
    logic [7:0]      rx;
    logic [23:0]     addr;
    logic [4:0]      bitcnt;
    logic            cont_mode;
    logic [7:0]      sh;
    logic [3:0]      left;
    logic [3:0]      out_q;
    logic [3:0]      oe_n_q;
    logic [2:0]      in_w;
    logic [2:0]      out_w;
    logic [7:0]      next_opc;
    logic [7:0]      next_mode;
    logic [7:0]      cur_byte;

    // Shift received lane bits into the low end of a word
    function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [3:0] io,
                                             input logic [2:0] w);
        shift_in = (w == 3'h2) ? {v[21:0], io[1], io[0]} : {v[22:0], io[0]};
    endfunction

    // Lane values for the leading bits of a byte
    function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] w);
        case (w)
            3'h4:    lane_bits = b[7:4];
            3'h2:    lane_bits = {2'h0, b[7], b[6]};
            default: lane_bits = {2'h0, b[7], 1'b0};
        endcase
    endfunction

    // Active-low enables of the lanes used at a width
    function automatic logic [3:0] lane_oe_n(input logic [2:0] w);
        case (w)
            3'h4:    lane_oe_n = 4'h0;
            3'h2:    lane_oe_n = 4'hC;
            default: lane_oe_n = 4'hD;
        endcase
    endfunction

    // Two-stage synchronisers for all link inputs
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_d  <= 1'b0;
            io_s1  <= 4'hF;
            io_s2  <= 4'hF;
        end else begin
            cs_s1  <= link.cs_n;
            cs_s2  <= cs_s1;
            sck_s1 <= link.sck;
            sck_s2 <= sck_s1;
            sck_d  <= sck_s2;
            io_s1  <= link.io_level;
            io_s2  <= io_s1;
        end
    end

    // Serial clock edges seen in the core domain
    assign sck_rise = sck_s2 & ~sck_d;
    assign sck_fall = ~sck_s2 & sck_d;

    // Lane widths of the current command
    assign in_w      = (state == D_ADDR || state == D_MODE) ? sfre_addr_lanes(opc) : 3'h1;
    assign out_w     = sfre_data_lanes(opc);
    assign next_opc  = {rx[6:0], io_s2[0]};
    assign next_mode = {rx[5:0], io_s2[1], io_s2[0]};

    // Array contents, loaded from the user side
    always_ff @(posedge sys_clk) begin
        if (load_en) begin
            mem[load_addr] <= load_data;
        end
    end

    // Current byte: fresh from the array or the remainder in the shifter
    assign cur_byte = (left == 4'h0) ? mem[addr[ARRAY_ADDR_BITS-1:0]] : sh; // RQ22

    // Command sequencer, address counter and continuous mode flag
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= D_IDLE;
            opc       <= 8'h00;
            rx        <= 8'h00;
            addr      <= 24'h000000;
            bitcnt    <= 5'h00;
            cont_mode <= 1'b0;
        end else if (cs_s2) begin
            state <= D_IDLE; // RQ7
        end else begin
            case (state)
                D_IDLE: begin
                    bitcnt <= 5'h00;
                    if (cont_mode) begin
                        opc   <= OPC_READ_DUAL_IO; // RQ12
                        state <= D_ADDR;
                    end else begin
                        state <= D_OPC;
                    end
                end
                D_OPC: if (sck_rise) begin
                    rx     <= next_opc;
                    bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == OPC_CLOCKS - 5'h01) begin
                        opc    <= next_opc;
                        bitcnt <= 5'h00;
                        case (next_opc)
                            OPC_READ_FAST, OPC_READ_SLOW, OPC_READ_DUAL_OUT,
                            OPC_READ_DUAL_IO: state <= D_ADDR; // RQ1 RQ2 RQ8 RQ11
                            OPC_READ_QUAD_OUT:
                                state <= quad_lane_permit_bit ? D_ADDR : D_IGNORE; // RQ17
                            OPC_MODE_RESET: begin
                                cont_mode <= 1'b0; // RQ16
                                state     <= D_IGNORE;
                            end
                            default: state <= D_IGNORE; // RQ21
                        endcase
                    end
                end
                D_ADDR: if (sck_rise) begin
                    addr   <= shift_in(addr, io_s2, in_w); // RQ3 RQ11
                    bitcnt <= bitcnt + {2'h0, in_w};
                    if (bitcnt + {2'h0, in_w} == ADDR_XFER_BITS) begin
                        bitcnt <= 5'h00;
                        if (opc == OPC_READ_DUAL_IO)
                            state <= D_MODE;
                        else if (sfre_has_dummy(opc))
                            state <= D_DUMMY; // RQ1 RQ8 RQ18
                        else
                            state <= D_DATA; // RQ2
                    end
                end
                D_MODE: if (sck_rise) begin
                    rx     <= next_mode;
                    bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == MODE_CLOCKS - 5'h01) begin // RQ24
                        // Only bits five and four matter; ones here end the mode
                        cont_mode <= (next_mode[MODE_SKIP_LSB+:2] == MODE_SKIP_CODE); // RQ12 RQ13 RQ14 RQ23
                        state     <= D_DATA;
                    end
                end
                D_DUMMY: if (sck_rise) begin
                    bitcnt <= bitcnt + 5'h01;
                    if (bitcnt == DUMMY_CLOCKS - 5'h01)
                        state <= D_DATA;
                end
                D_DATA: begin
                    // Next byte fetched at each byte boundary, wrapping past the top
                    if (sck_fall && left == 4'h0)
                        addr <= {4'h0, addr[ARRAY_ADDR_BITS-1:0] + 20'h00001}; // RQ4 RQ6
                end
                D_IGNORE: state <= D_IGNORE; // RQ21
                default: state <= D_IDLE;
            endcase
        end
    end

    // Data shifter and lane drivers; change on the falling serial edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sh     <= 8'h00;
            left   <= 4'h0;
            out_q  <= 4'h0;
            oe_n_q <= 4'hF;
        end else if (cs_s2 || state != D_DATA) begin
            left   <= 4'h0;
            out_q  <= 4'h0;
            oe_n_q <= 4'hF; // RQ7 RQ10 RQ20
        end else if (sck_fall) begin
            out_q  <= lane_bits(cur_byte, out_w); // RQ5 RQ9 RQ19
            sh     <= cur_byte << out_w;
            left   <= ((left == 4'h0) ? 4'h8 : left) - {1'b0, out_w};
            oe_n_q <= lane_oe_n(out_w); // RQ15
        end
    end

    // Link and status outputs
    assign link.dev_io_out  = out_q;
    assign link.dev_io_oe_n = oe_n_q;
    assign read_active      = (state == D_DATA);
    assign cont_read_active = cont_mode;

endmodule

// ---- rtl/sfre_host.sv ----
`timescale 1ns/1ps
module sfre_host
    import sfre_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // Serial link
    sfre_link_if.host        link,
    // Read request
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  mode_byte,
    input  wire logic [15:0] nbytes,
    input  wire logic        skip_opcode,
    // Read results
    output logic             busy,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             done
);

    typedef enum logic [3:0] {
        H_IDLE,
        H_SETUP,
        H_OPC,
        H_ADDR,
        H_MODE,
        H_DUMMY,
        H_RST,
        H_DATA,
        H_GAP
    } sfre_host_state_t;

    sfre_host_state_t state;
    sfre_host_state_t first_ph;
    logic [3:0]       div;
    logic             sck_q;
    logic             cs_n_q;
    logic [39:0]      tx;
    logic [4:0]       clk_left;
    logic [7:0]       opc_q;
    logic [15:0]      bytes_left;
    logic [7:0]       rx;
    logic [3:0]       rx_bits;
    logic [3:0]       io_s1;
    logic [3:0]       io_s2;
    logic             tick;
    logic             fall_ev;
    logic [2:0]       w;
    logic [7:0]       next_rx;

    // Lane width of the phase in progress
    always_comb begin
        case (state)
            H_ADDR:         w = sfre_addr_lanes(opc_q);
            H_MODE, H_RST:  w = 3'h2;
            H_DATA:         w = sfre_data_lanes(opc_q);
            default:        w = 3'h1;
        endcase
    end

    assign tick    = (div == 4'(SCK_HALF_CYC - 1));
    assign fall_ev = tick && sck_q;

    // Received lanes appended to the capture byte
    always_comb begin
        case (w)
            3'h4:    next_rx = {rx[3:0], io_s2};
            3'h2:    next_rx = {rx[5:0], io_s2[1:0]};
            default: next_rx = {rx[6:0], io_s2[1]};
        endcase
    end

    // Synchroniser for returned lanes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            io_s1 <= 4'hF;
            io_s2 <= 4'hF;
        end else begin
            io_s1 <= link.io_level;
            io_s2 <= io_s1;
        end
    end

    // Serial clock divider, running from frame start until the end of the closing gap
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div   <= 4'h0;
            sck_q <= 1'b0;
        end else if (state == H_IDLE) begin
            div   <= 4'h0;
            sck_q <= 1'b0;
        end else begin
            div <= tick ? 4'h0 : div + 4'h1;
            if (tick && state != H_SETUP && state != H_GAP && !(fall_ev && cs_n_q))
                sck_q <= ~sck_q;
        end
    end

    // Frame sequencer, driven on falling serial edges
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state        <= H_IDLE;
            first_ph     <= H_OPC;
            cs_n_q       <= 1'b1;
            tx           <= 40'h0;
            clk_left     <= 5'h00;
            opc_q        <= 8'h00;
            bytes_left   <= 16'h0000;
            rx           <= 8'h00;
            rx_bits      <= 4'h0;
            rd_data      <= 8'h00;
            rd_valid     <= 1'b0;
            done         <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            done     <= 1'b0;
            case (state)
                H_IDLE: if (start) begin
                    cs_n_q     <= 1'b0;
                    state      <= H_SETUP;
                    bytes_left <= (nbytes == 16'h0000) ? 16'h0001 : nbytes;
                    if (opcode == OPC_MODE_RESET) begin
                        opc_q    <= opcode;
                        tx       <= {40{1'b1}};
                        first_ph <= H_RST;
                        clk_left <= RESET_CLOCKS;
                    end else if (skip_opcode) begin
                        opc_q    <= OPC_READ_DUAL_IO;
                        tx       <= {addr, mode_byte, 8'h00};
                        first_ph <= H_ADDR;
                        clk_left <= 5'h0C;
                    end else begin
                        opc_q    <= opcode;
                        tx       <= {opcode, addr,
                                     (opcode == OPC_READ_DUAL_IO) ? mode_byte : 8'h00};
                        first_ph <= H_OPC;
                        clk_left <= OPC_CLOCKS;
                    end
                end
                H_SETUP: if (tick) state <= first_ph;
                H_GAP: if (tick) state <= H_IDLE;
                H_DATA: if (fall_ev) begin
                    // Device drove the first bits at the last header fall, so
                    // every fall in this phase carries a valid chunk
                    rx      <= next_rx;
                    rx_bits <= rx_bits + {1'b0, w};
                    if (rx_bits + {1'b0, w} == 4'h8) begin
                        rx_bits    <= 4'h0;
                        rd_data    <= next_rx;
                        rd_valid   <= 1'b1;
                        bytes_left <= bytes_left - 16'h0001;
                        if (bytes_left == 16'h0001) begin
                            cs_n_q <= 1'b1;
                            done   <= 1'b1;
                            state  <= H_GAP;
                        end
                    end
                end
                default: if (fall_ev) begin
                    tx       <= tx << w;
                    clk_left <= clk_left - 5'h01;
                    if (clk_left == 5'h01) begin
                        rx_bits <= 4'h0;
                        case (state)
                            H_OPC: begin
                                state    <= H_ADDR;
                                clk_left <= (sfre_addr_lanes(opc_q) == 3'h2) ? 5'h0C : 5'h18;
                            end
                            H_ADDR: begin
                                if (opc_q == OPC_READ_DUAL_IO) begin
                                    state    <= H_MODE;
                                    clk_left <= MODE_CLOCKS;
                                end else if (sfre_has_dummy(opc_q)) begin
                                    state    <= H_DUMMY;
                                    clk_left <= DUMMY_CLOCKS;
                                end else begin
                                    state <= H_DATA;
                                end
                            end
                            H_RST: begin
                                cs_n_q <= 1'b1;
                                done   <= 1'b1;
                                state  <= H_GAP;
                            end
                            default: state <= H_DATA;
                        endcase
                    end
                end
            endcase
        end
    end

    // Link drivers: lanes released for the whole data phase
    assign link.cs_n         = cs_n_q;
    assign link.sck          = sck_q;
    assign link.host_io_out  = (w == 3'h2) ? {2'h3, tx[39], tx[38]} : {3'h7, tx[39]};
    assign link.host_io_oe_n = (state == H_IDLE || state == H_GAP || state == H_DATA)
                               ? 4'hF : 4'hC;
    assign busy              = (state != H_IDLE);

endmodule

// ---- rtl/sfre_link_if.sv ----
`timescale 1ns/1ps
interface sfre_link_if;

    logic       cs_n;
    logic       sck;
    logic [3:0] host_io_out;
    logic [3:0] host_io_oe_n;
    logic [3:0] dev_io_out;
    logic [3:0] dev_io_oe_n;
    logic [3:0] io_level;

    // Wire level of each lane, pulled high when nobody drives
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!dev_io_oe_n[i])
                io_level[i] = dev_io_out[i];
            else if (!host_io_oe_n[i])
                io_level[i] = host_io_out[i];
            else
                io_level[i] = 1'b1;
        end
    end

    modport host (output cs_n, output sck, output host_io_out, output host_io_oe_n,
                  input io_level);
    modport dev  (input cs_n, input sck, input io_level,
                  output dev_io_out, output dev_io_oe_n);

endinterface

// ---- rtl/sfre_pkg.sv ----
package sfre_pkg;

    // Core clock and serial clock timing
    localparam int SYS_CLK_NS   = 40;
    localparam int SCK_HALF_NS  = 320;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

    // Read opcodes and the mode reset pattern
    localparam logic [7:0] OPC_READ_FAST     = 8'h0B;
    localparam logic [7:0] OPC_READ_SLOW     = 8'h03;
    localparam logic [7:0] OPC_READ_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OPC_READ_DUAL_IO  = 8'hBB;
    localparam logic [7:0] OPC_READ_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OPC_MODE_RESET    = 8'hFF;

    // Array size and frame field sizes
    localparam int         ARRAY_ADDR_BITS = 20;
    localparam int         ARRAY_BYTES     = 1 << ARRAY_ADDR_BITS;
    localparam logic [4:0] ADDR_XFER_BITS  = 5'h18;
    localparam logic [4:0] OPC_CLOCKS      = 5'h08;
    localparam logic [4:0] DUMMY_CLOCKS    = 5'h08;
    localparam logic [4:0] MODE_CLOCKS     = 5'h04;
    localparam logic [4:0] RESET_CLOCKS    = 5'h10;
    localparam logic [1:0] MODE_SKIP_CODE  = 2'h2;
    localparam int         MODE_SKIP_LSB   = 4;

    // Lanes used for data out per opcode
    function automatic logic [2:0] sfre_data_lanes(input logic [7:0] opc);
        case (opc)
            OPC_READ_DUAL_OUT, OPC_READ_DUAL_IO: sfre_data_lanes = 3'h2;
            OPC_READ_QUAD_OUT:                   sfre_data_lanes = 3'h4;
            default:                             sfre_data_lanes = 3'h1;
        endcase
    endfunction

    // Lanes used for address in per opcode
    function automatic logic [2:0] sfre_addr_lanes(input logic [7:0] opc);
        sfre_addr_lanes = (opc == OPC_READ_DUAL_IO) ? 3'h2 : 3'h1;
    endfunction

    // Opcodes that carry a dummy byte
    function automatic logic sfre_has_dummy(input logic [7:0] opc);
        sfre_has_dummy = (opc == OPC_READ_FAST) || (opc == OPC_READ_DUAL_OUT)
                      || (opc == OPC_READ_QUAD_OUT);
    endfunction

endpackage

// ---- tb/sfre_link_properties.sv ----
`timescale 1ns/1ps
module sfre_link_properties (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // Link signals
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic [3:0] host_io_out,
    input wire logic [3:0] host_io_oe_n,
    input wire logic [3:0] dev_io_out,
    input wire logic [3:0] dev_io_oe_n,
    input wire logic [3:0] io_level
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // Frame end and a device with all lanes free
    sequence frame_end;
        $rose(cs_n);
    endsequence
    sequence dev_free;
        dev_io_oe_n == 4'hF;
    endsequence

    // Release covers the sync delay of chip select
    release_tri_a: assert property (frame_end |-> ##[1:6] dev_free)
        else $error("device lanes driven after chip select release");
    idle_tri_a: assert property (cs_n [*8] |-> dev_free)
        else $error("device drives while deselected");
    lane_sets_a: assert property (dev_io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
        else $error("device drives an illegal lane set");
    no_clash_a: assert property ((~host_io_oe_n & ~dev_io_oe_n) == 4'h0)
        else $error("host and device drive one lane");
    drive_in_frame_a: assert property (dev_io_oe_n != 4'hF |-> !$past(cs_n, 8))
        else $error("device drives outside a frame");
    lanes_steady_a: assert property (dev_io_oe_n != 4'hF && $past(dev_io_oe_n) != 4'hF
        |-> $stable(dev_io_oe_n))
        else $error("device lane set changed within data phase");
    out_on_fall_a: assert property ($changed(dev_io_out) && dev_io_oe_n != 4'hF |-> !sck)
        else $error("device data changed while serial clock high");
    sck_quiet_a: assert property (cs_n && $past(cs_n) |-> !sck)
        else $error("serial clock runs outside a frame");
endmodule

// ---- tb/test_serial_flash_read_engine.sv ----
`timescale 1ns/1ps
module test_serial_flash_read_engine;
    import sfre_pkg::*;
    logic        sys_clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        permit  = 1'h1;
    logic        load_en = 1'h0;
    logic [19:0] load_addr = 20'h0;
    logic [7:0]  load_data = 8'h0;
    logic        read_active;
    logic        cont_read_active;
    logic        start = 1'h0;
    logic [7:0]  opcode = 8'h0;
    logic [23:0] addr = 24'h0;
    logic [7:0]  mode_byte = 8'h0;
    logic [15:0] nbytes = 16'h0;
    logic        skip_opcode = 1'h0;
    logic        busy;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        done;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    sfre_link_if link ();
    sfre_device u_sfre_device (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
        .quad_lane_permit_bit(permit), .load_en(load_en), .load_addr(load_addr),
        .load_data(load_data), .read_active(read_active), .cont_read_active(cont_read_active));
    sfre_host u_sfre_host (.sys_clk(sys_clk), .reset_n(reset_n), .link(link), .start(start),
        .opcode(opcode), .addr(addr), .mode_byte(mode_byte), .nbytes(nbytes),
        .skip_opcode(skip_opcode), .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done));
    sfre_link_properties u_props (.sys_clk(sys_clk), .reset_n(reset_n), .cs_n(link.cs_n),
        .sck(link.sck), .host_io_out(link.host_io_out), .host_io_oe_n(link.host_io_oe_n),
        .dev_io_out(link.dev_io_out), .dev_io_oe_n(link.dev_io_oe_n),
        .io_level(link.io_level));

    // Core clock
    always #20 sys_clk = ~sys_clk;

    // Compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end

    // One host frame; array byte at a is a[7:0]^C3, blank frames read the pull-up
    task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                       input logic [15:0] n, input logic sk, input logic blank);
        logic [15:0] got;
        logic [19:0] p;
        got = 16'h0;
        p = a[19:0];
        opcode <= op;
        addr <= a;
        mode_byte <= m;
        nbytes <= n;
        skip_opcode <= sk;
        start <= 1'h1;
        @(posedge sys_clk);
        start <= 1'h0;
        while (done !== 1'h1) begin
            @(posedge sys_clk);
            if (rd_valid === 1'h1) begin
                check("rd_data", {8'h0, rd_data}, blank ? 16'hFF : {8'h0, p[7:0] ^ 8'hC3});
                check("read_active", {15'h0, read_active}, {15'h0, !blank});
                p++;
                got++;
            end
        end
        check("byte_count", got, n);
        while (busy !== 1'h0)
            @(posedge sys_clk);
        check("read_active", {15'h0, read_active}, 16'h0);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        // Load the bytes around the wrap point
        for (int i = 0; i < 8; i++) begin
            load_en <= 1'h1;
            load_addr <= 20'hFFFFC + 20'(i);
            load_data <= (8'hFC + 8'(i)) ^ 8'hC3;
            @(posedge sys_clk);
        end
        load_en <= 1'h0;
        @(posedge sys_clk);
        run(OPC_READ_FAST, 24'hAFFFFE, 8'h0, 16'h4, 1'h0, 1'h0);
        run(OPC_READ_SLOW, 24'h0FFFFE, 8'h0, 16'h4, 1'h0, 1'h0);
        run(OPC_READ_DUAL_OUT, 24'h0FFFFF, 8'h0, 16'h3, 1'h0, 1'h0);
        run(OPC_READ_QUAD_OUT, 24'hFFFFFD, 8'h0, 16'h5, 1'h0, 1'h0);
        run(OPC_READ_DUAL_IO, 24'h000000, 8'hA5, 16'h2, 1'h0, 1'h0);
        check("cont_mode", {15'h0, cont_read_active}, 16'h1);
        run(OPC_READ_DUAL_IO, 24'h0FFFFE, 8'h00, 16'h3, 1'h1, 1'h0);
        check("cont_mode", {15'h0, cont_read_active}, 16'h0);
        run(OPC_READ_DUAL_IO, 24'h000001, 8'h2F, 16'h1, 1'h0, 1'h0);
        check("cont_mode", {15'h0, cont_read_active}, 16'h1);
        run(OPC_MODE_RESET, 24'h0, 8'h0, 16'h0, 1'h0, 1'h0);
        check("cont_mode", {15'h0, cont_read_active}, 16'h0);
        permit <= 1'h0;
        run(OPC_READ_QUAD_OUT, 24'h000000, 8'h0, 16'h2, 1'h0, 1'h1);
        run(8'h9F, 24'h000000, 8'h0, 16'h1, 1'h0, 1'h1);
        run(OPC_READ_FAST, 24'h000001, 8'h0, 16'h2, 1'h0, 1'h0);
        wrap_up();
    end
endmodule
